// ===== design/lic_pkg.sv
// Shared constants and types for the lamp and interrupt control block.
// Assumes a single 100 MHz clock and a station-management serial port.
package lic_pkg;

   // ---------------------------------------------------------------
   // Register numbers on the management port
   // ---------------------------------------------------------------
   localparam logic [4:0]  LIC_REG_LAMP   = 5'h14;
   localparam logic [4:0]  LIC_REG_RSVD   = 5'h15;
   localparam logic [4:0]  LIC_REG_INTC   = 5'h16;
   localparam logic [4:0]  LIC_REG_FLAG   = 5'h17;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] LIC_LAMP_RST   = 16'h3fe9;
   localparam logic [15:0] LIC_RSVD_RST   = 16'h0000;
   localparam logic [15:0] LIC_INTC_RST   = 16'h0000;
   localparam logic [10:0] LIC_FLAG_RST   = 11'h000;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int          LIC_SEL2_LSB   = 3;
   localparam int          LIC_SEL1_LSB   = 0;
   localparam int          LIC_OUT_EN     = 15;
   localparam int          LIC_RD_CLR     = 14;
   localparam int          LIC_POL        = 13;
   localparam int          LIC_AUTO_CLR   = 12;
   localparam int          LIC_REARM      = 11;
   localparam int          LIC_NUM_SRC    = 11;

   // ---------------------------------------------------------------
   // Serial management frame
   // ---------------------------------------------------------------
   localparam logic [5:0]  LIC_PRE_LEN    = 6'h20;
   localparam logic [5:0]  LIC_HDR_LAST   = 6'h0c;
   localparam logic [5:0]  LIC_DATA_LAST  = 6'h0f;
   localparam logic [1:0]  LIC_OP_RD      = 2'h2;
   localparam logic [1:0]  LIC_OP_WR      = 2'h1;

   typedef enum logic [2:0] {
      LIC_LAMP_LINK, LIC_LAMP_ACT, LIC_LAMP_TX, LIC_LAMP_RX,
      LIC_LAMP_COL, LIC_LAMP_SPEED, LIC_LAMP_FDX, LIC_LAMP_LAST
   } lic_lamp_e;

endpackage

// ===== design/lic_reg_if.sv
// Register request path between the serial port and the register file.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface lic_reg_if;
   logic [4:0]  addr;
   logic        wr;
   logic [15:0] wdata;
   logic        rd;
   logic [15:0] rdata;
   modport mgmt (output addr, output wr, output wdata, output rd, input rdata);
   modport regs (input addr, input wr, input wdata, input rd, output rdata);
endinterface

// ===== design/lic_lamp_select.sv
// One indicator lamp and its function selector.
// Assumes status inputs come from logic on the same clock.
`timescale 1ns/1ps
module lic_lamp_select #(
   parameter bit LAST_IS_LINK = 1'b0
) (
   // Clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_n,
   // Selector and status
   input  wire logic [2:0] i_sel,
   input  wire logic       i_link_up,
   input  wire logic       i_activity,
   input  wire logic       i_tx_active,
   input  wire logic       i_rx_active,
   input  wire logic       i_collision,
   input  wire logic       i_speed_100,
   input  wire logic       i_full_duplex,
   // Lamp
   output logic            o_lamp
);
   import lic_pkg::*;

   logic next_lamp;

   always_comb begin
      case (lic_lamp_e'(i_sel))
         LIC_LAMP_LINK:  next_lamp = i_link_up;
         LIC_LAMP_ACT:   next_lamp = i_activity;
         LIC_LAMP_TX:    next_lamp = i_tx_active;
         LIC_LAMP_RX:    next_lamp = i_rx_active;
         LIC_LAMP_COL:   next_lamp = i_collision;
         LIC_LAMP_SPEED: next_lamp = i_speed_100;
         LIC_LAMP_FDX:   next_lamp = i_full_duplex;
         default:        next_lamp = LAST_IS_LINK ? i_link_up : 1'b0;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_lamp <= 1'b0;
      end else begin
         o_lamp <= next_lamp;
      end
   end
endmodule

// ===== design/lic_mdio_slave.sv
// Serial management slave: frames, turnaround and register strobes.
// Assumes the management clock is far slower than the reference clock.
`timescale 1ns/1ps
module lic_mdio_slave #(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   // Clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   // Management pins
   input  wire logic i_mdc,
   input  wire logic i_mdio_in,
   output logic      o_mdio_out,
   output logic      o_mdio_oe,
   // Register requests
   lic_reg_if.mgmt   bus
);
   import lic_pkg::*;

   typedef enum logic [1:0] {ST_PRE, ST_HDR, ST_TA, ST_DATA} lic_mdio_e;

   logic [2:0]  mdc_s;
   logic [2:0]  dio_s;
   logic        mdc_f;
   logic        dio_f;
   logic        rise;
   lic_mdio_e   state;
   logic [5:0]  cnt;
   logic [15:0] sh;
   logic [15:0] rdsh;
   logic        is_rd;
   logic [12:0] hdr;

   // A pin level counts only once the last two stages agree.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mdc_s <= 3'h0;
         dio_s <= 3'h0;
         mdc_f <= 1'b0;
         dio_f <= 1'b0;
      end else begin
         mdc_s <= {mdc_s[1:0], i_mdc};
         dio_s <= {dio_s[1:0], i_mdio_in};
         if (mdc_s[1] == mdc_s[2]) begin
            mdc_f <= mdc_s[2];
         end
         if (dio_s[1] == dio_s[2]) begin
            dio_f <= dio_s[2];
         end
      end
   end

   assign rise = (mdc_s[1] == mdc_s[2]) && mdc_s[2] && !mdc_f;
   assign hdr  = {sh[11:0], dio_f};

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state     <= ST_PRE;
         cnt       <= 6'h00;
         sh        <= 16'h0000;
         is_rd     <= 1'b0;
         bus.addr  <= 5'h00;
         bus.wdata <= 16'h0000;
      end else if (rise) begin
         sh <= {sh[14:0], dio_f};
         case (state)
            ST_PRE: begin
               if (dio_f) begin
                  cnt <= (cnt == LIC_PRE_LEN) ? cnt : cnt + 6'h01;
               end else begin
                  state <= (cnt == LIC_PRE_LEN) ? ST_HDR : ST_PRE;
                  cnt   <= 6'h00;
               end
            end
            ST_HDR: begin
               cnt <= cnt + 6'h01;
               if (cnt == LIC_HDR_LAST) begin
                  cnt      <= 6'h00;
                  is_rd    <= hdr[11:10] == LIC_OP_RD;
                  bus.addr <= hdr[4:0];
                  if (hdr[12] && hdr[9:5] == PHY_ADDR &&
                      (hdr[11:10] == LIC_OP_RD || hdr[11:10] == LIC_OP_WR)) begin
                     state <= ST_TA;
                  end else begin
                     state <= ST_PRE;
                  end
               end
            end
            ST_TA: begin
               cnt <= cnt + 6'h01;
               if (cnt == 6'h01) begin
                  cnt   <= 6'h00;
                  state <= ST_DATA;
               end
            end
            default: begin
               cnt <= cnt + 6'h01;
               if (cnt == LIC_DATA_LAST) begin
                  cnt       <= 6'h00;
                  state     <= ST_PRE;
                  bus.wdata <= {sh[14:0], dio_f};
               end
            end
         endcase
      end
   end

   // Strobes are single reference-clock pulses.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bus.rd <= 1'b0;
         bus.wr <= 1'b0;
      end else begin
         bus.rd <= rise && state == ST_HDR && cnt == LIC_HDR_LAST && hdr[12] &&
                   hdr[9:5] == PHY_ADDR && hdr[11:10] == LIC_OP_RD;
         bus.wr <= rise && state == ST_DATA && cnt == LIC_DATA_LAST && !is_rd;
      end
   end

   // The pin is driven from the second turnaround bit to the last data bit.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdsh       <= 16'h0000;
         o_mdio_out <= 1'b0;
         o_mdio_oe  <= 1'b0;
      end else if (bus.rd) begin
         rdsh <= bus.rdata;
      end else if (rise && is_rd) begin
         if (state == ST_TA && cnt == 6'h00) begin
            o_mdio_oe  <= 1'b1;
            o_mdio_out <= 1'b0;
         end else if (state == ST_TA || (state == ST_DATA && cnt != LIC_DATA_LAST)) begin
            o_mdio_out <= rdsh[15];
            rdsh       <= {rdsh[14:0], 1'b0};
         end else begin
            o_mdio_oe  <= 1'b0;
            o_mdio_out <= 1'b0;
         end
      end
   end
endmodule

// ===== design/lic_led_int_ctrl.sv
// Lamp function selection and interrupt control with its registers.
// Assumes event conditions and lamp status come from the same clock.
//
// Behaviour
// - second lamp follows its 3-bit selector; reset selects speed indication.
// - first lamp follows its selector, code 111 shows link; reset is activity.
// - interrupt pin driven only when enabled; polarity bit picks level; both reset zero.
// - with read-clear set, reading the flags clears them; otherwise reading keeps them.
// - with auto-clear set, a flag clears once its condition is gone.
// - write-one clears a flag, unless re-arm is set and condition persists.
// - deep-sleep wake raises an interrupt only when its enable is set.
// - deep-sleep entry and negotiation complete each gated by their enable.
// - the reserved register is sixteen read/write bits resetting to zero.
// - one latched write-one-clear flag per interrupt source, eleven sources.
// - low eight enable bits gate the eight lower event interrupts.
`timescale 1ns/1ps
module lic_led_int_ctrl #(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   // Clock and reset
   input  wire logic                         i_ref_clk,
   input  wire logic                         i_rst_n,
   // Management pins
   input  wire logic                         i_mdc,
   input  wire logic                         i_mdio_in,
   output logic                              o_mdio_out,
   output logic                              o_mdio_oe,
   // Lamp status
   input  wire logic                         i_link_up,
   input  wire logic                         i_activity,
   input  wire logic                         i_tx_active,
   input  wire logic                         i_rx_active,
   input  wire logic                         i_collision,
   input  wire logic                         i_speed_100,
   input  wire logic                         i_full_duplex,
   // Interrupt conditions
   input  wire logic [lic_pkg::LIC_NUM_SRC-1:0] i_int_cond,
   // Lamps and interrupt pin
   output logic                              o_first_lamp,
   output logic                              o_second_lamp,
   output logic                              o_int_out,
   output logic                              o_int_oe
);
   import lic_pkg::*;

   lic_reg_if bus ();

   logic [15:0]            lamp_reg;
   logic [15:0]            rsvd_reg;
   logic [15:0]            intc_reg;
   logic [LIC_NUM_SRC-1:0] flags;
   logic [LIC_NUM_SRC-1:0] cond_q;
   logic [LIC_NUM_SRC-1:0] edges;
   logic [LIC_NUM_SRC-1:0] next_flags;
   logic [LIC_NUM_SRC-1:0] clr;
   logic                   wr_lamp;
   logic                   wr_rsvd;
   logic                   wr_intc;
   logic                   wr_flag;
   logic                   rd_flag;
   logic                   pending;

   // ---------------------------------------------------------------
   // Serial port and lamps
   // ---------------------------------------------------------------
   lic_mdio_slave #(
      .PHY_ADDR   (PHY_ADDR)
   ) u_mdio (
      .i_ref_clk  (i_ref_clk),
      .i_rst_n    (i_rst_n),
      .i_mdc      (i_mdc),
      .i_mdio_in  (i_mdio_in),
      .o_mdio_out (o_mdio_out),
      .o_mdio_oe  (o_mdio_oe),
      .bus        (bus.mgmt)
   );

   lic_lamp_select #(
      .LAST_IS_LINK  (1'b1)
   ) u_first_lamp (
      .i_ref_clk     (i_ref_clk),
      .i_rst_n       (i_rst_n),
      .i_sel         (lamp_reg[LIC_SEL1_LSB +: 3]),
      .i_link_up     (i_link_up),
      .i_activity    (i_activity),
      .i_tx_active   (i_tx_active),
      .i_rx_active   (i_rx_active),
      .i_collision   (i_collision),
      .i_speed_100   (i_speed_100),
      .i_full_duplex (i_full_duplex),
      .o_lamp        (o_first_lamp)
   );

   lic_lamp_select #(
      .LAST_IS_LINK  (1'b0)
   ) u_second_lamp (
      .i_ref_clk     (i_ref_clk),
      .i_rst_n       (i_rst_n),
      .i_sel         (lamp_reg[LIC_SEL2_LSB +: 3]),
      .i_link_up     (i_link_up),
      .i_activity    (i_activity),
      .i_tx_active   (i_tx_active),
      .i_rx_active   (i_rx_active),
      .i_collision   (i_collision),
      .i_speed_100   (i_speed_100),
      .i_full_duplex (i_full_duplex),
      .o_lamp        (o_second_lamp)
   );

   // ---------------------------------------------------------------
   // Address decode and read data
   // ---------------------------------------------------------------
   always_comb begin
      wr_lamp = 1'b0;
      wr_rsvd = 1'b0;
      wr_intc = 1'b0;
      wr_flag = 1'b0;
      rd_flag = 1'b0;
      if (bus.addr == LIC_REG_LAMP) begin
         wr_lamp = bus.wr;
      end else if (bus.addr == LIC_REG_RSVD) begin
         wr_rsvd = bus.wr;
      end else if (bus.addr == LIC_REG_INTC) begin
         wr_intc = bus.wr;
      end else if (bus.addr == LIC_REG_FLAG) begin
         wr_flag = bus.wr;
         rd_flag = bus.rd;
      end
   end

   // Unmapped registers read as zero so a scan of the map is harmless.
   always_comb begin
      if (bus.addr == LIC_REG_LAMP) begin
         bus.rdata = lamp_reg;
      end else if (bus.addr == LIC_REG_RSVD) begin
         bus.rdata = rsvd_reg;
      end else if (bus.addr == LIC_REG_INTC) begin
         bus.rdata = intc_reg;
      end else if (bus.addr == LIC_REG_FLAG) begin
         bus.rdata = {5'h00, flags};
      end else begin
         bus.rdata = 16'h0000;
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lamp_reg <= LIC_LAMP_RST;
      end else if (wr_lamp) begin
         lamp_reg <= bus.wdata;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rsvd_reg <= LIC_RSVD_RST;
      end else if (wr_rsvd) begin
         rsvd_reg <= bus.wdata;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         intc_reg <= LIC_INTC_RST;
      end else if (wr_intc) begin
         intc_reg <= bus.wdata;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt flags
   // ---------------------------------------------------------------
   // Flags latch on the rising edge of a condition, so a condition that
   // stays high cannot defeat an unconditional write-one clear.
   assign edges = i_int_cond & ~cond_q;

   always_comb begin
      for (int i = 0; i < LIC_NUM_SRC; i++) begin
         clr[i] = (wr_flag && bus.wdata[i] && !(intc_reg[LIC_REARM] && i_int_cond[i]))
                  || (rd_flag && intc_reg[LIC_RD_CLR])
                  || (intc_reg[LIC_AUTO_CLR] && !i_int_cond[i]);
      end
      // A new event in the same cycle as a clear is kept.
      next_flags = edges | (flags & ~clr);
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cond_q <= LIC_FLAG_RST;
         flags  <= LIC_FLAG_RST;
      end else begin
         cond_q <= i_int_cond;
         flags  <= next_flags;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt pin
   // ---------------------------------------------------------------
   assign pending = |(flags & intc_reg[LIC_NUM_SRC-1:0]);

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_int_out <= 1'b1;
      end else begin
         o_int_out <= intc_reg[LIC_POL] ~^ pending;
      end
   end

   assign o_int_oe = intc_reg[LIC_OUT_EN];

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);

   a_second_lamp_speed: assert property (
      lamp_reg[5:3] == 3'h5 && !wr_lamp |=> o_second_lamp == $past(i_speed_100))
      else $error("second lamp does not follow speed");

   a_second_lamp_off: assert property (
      lamp_reg[5:3] == 3'h7 |=> !o_second_lamp)
      else $error("second lamp lit while off");

   a_first_lamp_link: assert property (
      lamp_reg[2:0] == 3'h7 |=> o_first_lamp == $past(i_link_up))
      else $error("first lamp does not show link");

   a_int_out_enable: assert property (
      wr_intc |=> o_int_oe == $past(bus.wdata[LIC_OUT_EN]))
      else $error("interrupt enable not applied");

   a_read_clears: assert property (
      rd_flag && intc_reg[LIC_RD_CLR] && edges == 0 |=> flags == 0)
      else $error("read did not clear flags");

   a_read_keeps: assert property (
      rd_flag && !intc_reg[LIC_RD_CLR] && !intc_reg[LIC_AUTO_CLR] && !wr_flag
      |=> (flags & $past(flags)) == $past(flags))
      else $error("read changed flags");

   a_auto_clear: assert property (
      intc_reg[LIC_AUTO_CLR] |=> (flags & ~$past(i_int_cond) & ~$past(edges)) == 0)
      else $error("flag kept after condition removed");

   a_w1c_plain: assert property (
      wr_flag && !intc_reg[LIC_REARM] |=> (flags & $past(bus.wdata[10:0] & ~edges)) == 0)
      else $error("write one did not clear");

   a_w1c_rearm: assert property (
      wr_flag && intc_reg[LIC_REARM] && !rd_flag && !intc_reg[LIC_AUTO_CLR]
      |=> (flags & $past(flags & i_int_cond)) == $past(flags & i_int_cond))
      else $error("rearmed flag lost");

   a_flag_latch: assert property (
      edges != 0 |=> (flags & $past(edges)) == $past(edges))
      else $error("event not latched");

   a_rsvd_hold: assert property (
      !wr_rsvd |=> rsvd_reg == $past(rsvd_reg))
      else $error("reserved register changed");

   a_pin_level: assert property (
      ##1 o_int_out == ($past(intc_reg[LIC_POL]) ~^ $past(pending)))
      else $error("interrupt level wrong");

   a_first_lamp_act: assert property (
      lamp_reg[2:0] == 3'h1 |=> o_first_lamp == $past(i_activity))
      else $error("first lamp does not follow activity");

   a_lamp_write: assert property (
      wr_lamp |=> lamp_reg == $past(bus.wdata))
      else $error("lamp register write lost");

   a_rsvd_write: assert property (
      wr_rsvd |=> rsvd_reg == $past(bus.wdata))
      else $error("reserved register write lost");

   a_flag_hold: assert property (
      !intc_reg[LIC_AUTO_CLR] && !rd_flag && !wr_flag |=> (flags & $past(flags)) == $past(flags))
      else $error("flag cleared without a clear");

   a_wake_gate: assert property (
      !intc_reg[10] && (flags[9:0] & intc_reg[9:0]) == 10'h000
      |=> o_int_out == !$past(intc_reg[LIC_POL]))
      else $error("disabled wake event raised the pin");

   a_sleep_gate: assert property (
      intc_reg[9:8] == 2'b00 && (flags[10] & intc_reg[10]) == 1'b0 && (flags[7:0] & intc_reg[7:0]) == 8'h00
      |=> o_int_out == !$past(intc_reg[LIC_POL]))
      else $error("disabled sleep or negotiation event raised the pin");

   a_low_gate: assert property (
      intc_reg[7:0] == 8'h00 && (flags[10:8] & intc_reg[10:8]) == 3'h0
      |=> o_int_out == !$past(intc_reg[LIC_POL]))
      else $error("disabled lower event raised the pin");

endmodule

// ===== verif/lic_sta_model.sv
// Station management controller model: drives the management clock and data pin.
// Assumes a pull-up on the data pin and the device's reference clock for pacing.
`timescale 1ns/1ps
module lic_sta_model
   import lic_pkg::*;
(
   // Clock
   input  wire logic i_ref_clk,
   // Device side of the data pin
   input  wire logic i_mdio_out,
   input  wire logic i_mdio_oe,
   // Management pins
   output logic      o_mdc,
   output logic      o_mdio
);
   logic drv_en;
   logic drv_val;

   // The pull-up wins whenever neither party drives, so a released pin reads one.
   assign o_mdio = i_mdio_oe ? i_mdio_out : (drv_en ? drv_val : 1'b1);

   initial begin
      o_mdc = 1'b0;
      drv_en = 1'b0;
      drv_val = 1'b1;
   end

   // ---------------------------------------------------------------
   // One bit period, six reference cycles low and five high
   // ---------------------------------------------------------------
   task automatic clk_bit(input logic en, input logic val, output logic seen);
      @(posedge i_ref_clk);
      drv_en <= en;
      drv_val <= val;
      repeat (5) @(posedge i_ref_clk);
      seen = o_mdio;
      o_mdc <= 1'b1;
      repeat (5) @(posedge i_ref_clk);
      o_mdc <= 1'b0;
   endtask

   // The clock stands still low between frames.
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic        s;
      logic        rdop;
      logic [13:0] hdr;
      rdop = (op == LIC_OP_RD);
      hdr = {2'b01, op, phy, ra};
      for (int i = 0; i < 32; i++) clk_bit(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) clk_bit(1'b1, hdr[i], s);
      clk_bit(!rdop, 1'b1, s);
      clk_bit(!rdop, 1'b0, s);
      for (int i = 15; i >= 0; i--) begin
         clk_bit(!rdop, wd[i], s);
         rd[i] = s;
      end
      @(posedge i_ref_clk);
      drv_en <= 1'b0;
   endtask
endmodule

// ===== verif/test_led_and_interrupt_control.sv
// Self-checking bench for the lamp and interrupt control block.
// Assumes the station model above and a single 100 MHz reference clock.
`timescale 1ns/1ps
module test_led_and_interrupt_control;
   import lic_pkg::*;
   logic        i_ref_clk;
   logic        i_rst_n;
   logic        mdc;
   logic        mdio;
   logic        mdio_out;
   logic        mdio_oe;
   logic [6:0]  st;
   logic [10:0] cond;
   logic [10:0] en;
   logic        lamp1;
   logic        lamp2;
   logic        int_out;
   logic        int_oe;
   logic [15:0] rd;
   int          mismatches;
   int          comparisons;
   int          cycles;
   integer      seed;

   lic_led_int_ctrl #(.PHY_ADDR(5'h01)) dut_u (
      .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_mdc(mdc), .i_mdio_in(mdio),
      .o_mdio_out(mdio_out), .o_mdio_oe(mdio_oe), .i_link_up(st[0]), .i_activity(st[1]),
      .i_tx_active(st[2]), .i_rx_active(st[3]), .i_collision(st[4]), .i_speed_100(st[5]),
      .i_full_duplex(st[6]), .i_int_cond(cond), .o_first_lamp(lamp1), .o_second_lamp(lamp2),
      .o_int_out(int_out), .o_int_oe(int_oe));

   lic_sta_model sta_u (
      .i_ref_clk(i_ref_clk), .i_mdio_out(mdio_out), .i_mdio_oe(mdio_oe), .o_mdc(mdc), .o_mdio(mdio));

   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic rd_reg(input logic [4:0] ra, output logic [15:0] d);
      sta_u.frame(LIC_OP_RD, 5'h01, ra, 16'h0000, d);
   endtask

   task automatic wr_reg(input logic [4:0] ra, input logic [15:0] d);
      logic [15:0] unused;
      sta_u.frame(LIC_OP_WR, 5'h01, ra, d, unused);
      repeat (4) @(posedge i_ref_clk);
   endtask

   task automatic set_cond(input int s, input logic v);
      @(posedge i_ref_clk);
      cond[s] <= v;
      repeat (3) @(posedge i_ref_clk);
   endtask

   // Code seven lights link on the first lamp and nothing on the second.
   function automatic logic lamp_exp(input logic [2:0] sel, input logic [6:0] s, input logic first);
      return (sel == 3'h7) ? (first & s[0]) : s[sel];
   endfunction

   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   initial begin
      seed = 32'h97ea70e3;
      i_rst_n = 1'b0;
      st = 7'h00;
      cond = 11'h000;
      repeat (2) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      rd_reg(LIC_REG_LAMP, rd); check(rd, LIC_LAMP_RST);
      rd_reg(LIC_REG_RSVD, rd); check(rd, 16'h0000);
      rd_reg(LIC_REG_INTC, rd); check(rd, 16'h0000);
      rd_reg(LIC_REG_FLAG, rd); check(rd, 16'h0000);
      rd_reg(5'h1f, rd); check(rd, 16'h0000);
      check(16'(int_oe), 16'h0000);
      sta_u.frame(LIC_OP_RD, 5'h02, LIC_REG_LAMP, 16'h0000, rd); check(rd, 16'hffff);
      $display("Test reset_values done");
      for (int c = 0; c < 8; c++) begin
         wr_reg(LIC_REG_LAMP, {LIC_LAMP_RST[15:6], 3'(7 - c), 3'(c)});
         rd_reg(LIC_REG_LAMP, rd); check(rd, {LIC_LAMP_RST[15:6], 3'(7 - c), 3'(c)});
         repeat (4) begin
            @(posedge i_ref_clk);
            st <= 7'($random(seed));
            repeat (3) @(posedge i_ref_clk);
            check(16'(lamp1), 16'(lamp_exp(3'(c), st, 1'b1)));
            check(16'(lamp2), 16'(lamp_exp(3'(7 - c), st, 1'b0)));
         end
      end
      $display("Test lamp_select done");
      for (int s = 0; s < 11; s++) begin
         en = 11'($random(seed));
         en[s] = s[0];
         wr_reg(LIC_REG_INTC, {5'b10000, en});
         check(16'(int_oe), 16'h0001);
         set_cond(s, 1'b1);
         check(16'(int_out), 16'(!en[s]));
         wr_reg(LIC_REG_INTC, {5'b10000, en ^ (11'h001 << s)});
         check(16'(int_out), 16'(en[s]));
         rd_reg(LIC_REG_FLAG, rd); check(rd, 16'h0001 << s);
         wr_reg(LIC_REG_FLAG, 16'h0001 << s);
         rd_reg(LIC_REG_FLAG, rd); check(rd, 16'h0000);
         check(16'(int_out), 16'h0001);
         set_cond(s, 1'b0);
      end
      $display("Test source_gating done");
      wr_reg(LIC_REG_INTC, 16'ha7ff);
      set_cond(3, 1'b1);
      check(16'(int_out), 16'h0001);
      set_cond(3, 1'b0);
      rd_reg(LIC_REG_FLAG, rd); check(rd, 16'h0008);
      rd_reg(LIC_REG_FLAG, rd); check(rd, 16'h0008);
      wr_reg(LIC_REG_INTC, 16'he7ff);
      rd_reg(LIC_REG_FLAG, rd); check(rd, 16'h0008);
      rd_reg(LIC_REG_FLAG, rd); check(rd, 16'h0000);
      check(16'(int_out), 16'h0000);
      wr_reg(LIC_REG_INTC, 16'hb7ff);
      set_cond(5, 1'b1);
      rd_reg(LIC_REG_FLAG, rd); check(rd, 16'h0020);
      set_cond(5, 1'b0);
      rd_reg(LIC_REG_FLAG, rd); check(rd, 16'h0000);
      wr_reg(LIC_REG_INTC, 16'h8fff);
      set_cond(1, 1'b1);
      wr_reg(LIC_REG_FLAG, 16'h0002);
      rd_reg(LIC_REG_FLAG, rd); check(rd, 16'h0002);
      set_cond(1, 1'b0);
      wr_reg(LIC_REG_FLAG, 16'h0002);
      rd_reg(LIC_REG_FLAG, rd); check(rd, 16'h0000);
      check(16'(int_out), 16'h0001);
      wr_reg(LIC_REG_INTC, 16'h0000);
      check(16'(int_oe), 16'h0000);
      $display("Test clear_policies done");
      tally_and_finish();
   end
endmodule
